// file: verilog/rfs_map.svh
// Register offsets, field positions and limits of the frame status and transmit enqueue block.
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH

// ****************************************
// Device register offsets
// ****************************************
`define RFS_OFF_STATUS  8'h7c
`define RFS_OFF_BYTES   8'h7e
`define RFS_OFF_TXCMD   8'h80
`define RFS_OFF_RXCMD   8'h82
`define RFS_OFF_FCOUNT  8'h90
`define RFS_OFF_IRQ     8'h92
`define RFS_OFF_TXREQ   8'h9e

// ****************************************
// Field positions
// ****************************************
`define RFS_B_VALID     15
`define RFS_B_TCP       11
`define RFS_B_UDP       10
`define RFS_B_BCAST     7
`define RFS_B_MCAST     6
`define RFS_B_UCAST     5
`define RFS_B_SYMBOL    4
`define RFS_B_TYPE      3
`define RFS_B_LONG      2
`define RFS_B_RUNT      1
`define RFS_B_CRC       0
`define RFS_B_AUTO      2
`define RFS_B_WATCH     1
`define RFS_B_SINGLE    0
`define RFS_B_RELEASE   0
`define RFS_B_IRQSPACE  6
`define RFS_B_GROUP     40

// ****************************************
// Limits and sizes
// ****************************************
`define RFS_TYPE_LIMIT  16'h05dc
`define RFS_LONG_LIMIT  12'h7d0
`define RFS_DEPTH       4'h8
`define RFS_PTR_W       3
`define RFS_CNT_W       4

// ****************************************
// Host Wishbone offsets and bit positions
// ****************************************
`define RFS_WB_CMD      4'h0
`define RFS_WB_WDATA    4'h4
`define RFS_WB_RDATA    4'h8
`define RFS_WB_B_WRITE  8
`define RFS_WB_B_BUSY   16

`endif

// file: verilog/rfs_pkg.sv
// Types shared by both ends of the frame status and transmit enqueue block.
package rfs_pkg;
  typedef logic [15:0] rfs_word_type;
  typedef logic [7:0]  rfs_addr_type;
  typedef enum logic {HIdle, HReq} rfs_host_state_type;
endpackage

// file: verilog/rfs_link_if.sv
// Register port joining the host end to the device end.
`timescale 1ns/1ps
interface rfs_link_if;
  import rfs_pkg::*;
  rfs_addr_type regAddr;
  rfs_word_type regWrData;
  logic         regWr;
  logic         regRd;
  rfs_word_type regRdData;
  logic         regAck;

  modport device (
    input  regAddr,
    input  regWrData,
    input  regWr,
    input  regRd,
    output regRdData,
    output regAck
  );
  modport host (
    output regAddr,
    output regWrData,
    output regWr,
    output regRd,
    input  regRdData,
    input  regAck
  );
endinterface

// file: verilog/rfs_device.sv
// Device end: receive frame status queue, byte count report and transmit enqueue commands.
`timescale 1ns/1ps
`include "rfs_map.svh"
module rfs_device (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Register port
  rfs_link_if.device            link,
  // Receive frame report from the MAC
  input  wire logic             rxFrameDone,
  input  wire logic [47:0]      rxDestAddr,
  input  wire rfs_pkg::rfs_word_type rxLenType,
  input  wire logic [11:0]      rxByteCount,
  input  wire logic             rxTcpBad,
  input  wire logic             rxUdpBad,
  input  wire logic             rxSymbolErr,
  input  wire logic             rxRunt,
  input  wire logic             rxCrcBad,
  input  wire logic             passBadFrame,
  // Transmit queue side and receive drop flag
  input  wire logic             txFramePrepared,
  input  wire logic             txFrameSent,
  input  wire logic [12:0]      txFreeBytes,
  output logic                  txEnqueue,
  output logic                  rxDropped
);
  import rfs_pkg::*;

  // ****************************************
  // Receive status queue
  // ****************************************
  rfs_word_type          statusMem [0:7];
  logic [11:0]           bytesMem  [0:7];
  logic [`RFS_PTR_W-1:0] wrPtr_reg;
  logic [`RFS_PTR_W-1:0] rdPtr_reg;
  logic [`RFS_CNT_W-1:0] count_reg;
  logic                  isBroadcast;
  logic                  isGroup;
  logic                  isLong;
  logic                  isType;
  logic                  isBad;
  logic                  push;
  logic                  pop;
  rfs_word_type          newStatus;

  // Register port and command state
  logic                  ack_reg;
  rfs_word_type          rdData_reg;
  logic                  access;
  logic                  wrHit;
  logic                  autoQueue_reg;
  logic                  spaceWatch_reg;
  logic                  singleQueue_reg;
  logic                  irqSpace_reg;
  logic [12:0]           txRequest_reg;
  logic                  txEnqueue_reg;
  logic                  rxDropped_reg;
  logic                  spaceReached;
  logic                  singleStart;
  rfs_word_type          headStatus;
  logic [11:0]           headBytes;

  always_comb begin
    isBroadcast = &rxDestAddr;
    isGroup     = rxDestAddr[`RFS_B_GROUP];
    isLong      = rxByteCount > `RFS_LONG_LIMIT;
    isType      = (rxLenType > `RFS_TYPE_LIMIT) && !rxRunt;
    isBad       = isLong || rxRunt || rxCrcBad;
    newStatus   = 16'h0000;
    newStatus[`RFS_B_VALID]  = 1'b1;
    newStatus[`RFS_B_TCP]    = rxTcpBad;
    newStatus[`RFS_B_UDP]    = rxUdpBad;
    newStatus[`RFS_B_BCAST]  = isBroadcast;
    newStatus[`RFS_B_MCAST]  = isGroup;
    newStatus[`RFS_B_UCAST]  = !isGroup;
    newStatus[`RFS_B_SYMBOL] = rxSymbolErr;
    newStatus[`RFS_B_TYPE]   = isType;
    newStatus[`RFS_B_LONG]   = isLong;
    newStatus[`RFS_B_RUNT]   = rxRunt;
    newStatus[`RFS_B_CRC]    = rxCrcBad;
  end

  // A full queue drops the new report rather than overwrite an entry the host has not read.
  assign push = rxFrameDone && (!isBad || passBadFrame) && (count_reg != `RFS_DEPTH);
  assign access = (link.regWr || link.regRd) && !ack_reg;
  assign wrHit  = access && link.regWr;
  assign pop = wrHit && (link.regAddr == `RFS_OFF_RXCMD) && link.regWrData[`RFS_B_RELEASE]
               && (count_reg != 4'h0);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      statusMem[wrPtr_reg] <= newStatus;
      bytesMem[wrPtr_reg]  <= rxByteCount;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr_reg <= 3'h0;
      rdPtr_reg <= 3'h0;
      count_reg <= 4'h0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 3'h1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 3'h1;
      end
      count_reg <= count_reg + {3'h0, push} - {3'h0, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxDropped_reg <= 1'b0;
    end else begin
      rxDropped_reg <= rxFrameDone && !push;
    end
  end

  // An empty queue shows no valid head, so a frame still arriving never reads valid.
  always_comb begin
    headStatus = 16'h0000;
    headBytes  = 12'h000;
    if (count_reg != 4'h0) begin
      headStatus = statusMem[rdPtr_reg];
      headBytes  = bytesMem[rdPtr_reg];
    end
  end

  // ****************************************
  // Transmit commands
  // ****************************************
  assign singleStart = wrHit && (link.regAddr == `RFS_OFF_TXCMD) && link.regWrData[`RFS_B_SINGLE];
  assign spaceReached = spaceWatch_reg && (txFreeBytes >= txRequest_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      autoQueue_reg <= 1'b0;
    end else if (wrHit && link.regAddr == `RFS_OFF_TXCMD) begin
      autoQueue_reg <= link.regWrData[`RFS_B_AUTO];
    end
  end

  // A manual start while a frame is still pending is ignored, so the host must wait for the clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      singleQueue_reg <= 1'b0;
    end else if (singleStart && !singleQueue_reg) begin
      singleQueue_reg <= 1'b1;
    end else if (txFrameSent && singleQueue_reg) begin
      singleQueue_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txEnqueue_reg <= 1'b0;
    end else begin
      txEnqueue_reg <= (autoQueue_reg && txFramePrepared)
                       || (singleStart && !singleQueue_reg && !autoQueue_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spaceWatch_reg <= 1'b0;
    end else if (wrHit && link.regAddr == `RFS_OFF_TXCMD && link.regWrData[`RFS_B_WATCH]) begin
      spaceWatch_reg <= 1'b1;
    end else if (spaceReached) begin
      spaceWatch_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txRequest_reg <= 13'h0000;
    end else if (wrHit && link.regAddr == `RFS_OFF_TXREQ) begin
      txRequest_reg <= link.regWrData[12:0];
    end
  end

  // Write one clears; a new event in the same cycle keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqSpace_reg <= 1'b0;
    end else begin
      irqSpace_reg <= spaceReached
                      || (irqSpace_reg && !(wrHit && link.regAddr == `RFS_OFF_IRQ
                                            && link.regWrData[`RFS_B_IRQSPACE]));
    end
  end

  // ****************************************
  // Register port answer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_reg <= 16'h0000;
    end else if (access && link.regRd) begin
      case (link.regAddr)
        `RFS_OFF_STATUS: rdData_reg <= headStatus;
        `RFS_OFF_BYTES:  rdData_reg <= {4'h0, headBytes};
        `RFS_OFF_TXCMD:  rdData_reg <= {13'h0000, autoQueue_reg, spaceWatch_reg, singleQueue_reg};
        `RFS_OFF_FCOUNT: rdData_reg <= {12'h000, count_reg};
        `RFS_OFF_IRQ:    rdData_reg <= {9'h000, irqSpace_reg, 6'h00};
        `RFS_OFF_TXREQ:  rdData_reg <= {3'h0, txRequest_reg};
        default:         rdData_reg <= 16'h0000;
      endcase
    end
  end

  assign link.regAck    = ack_reg;
  assign link.regRdData = rdData_reg;
  assign txEnqueue      = txEnqueue_reg;
  assign rxDropped      = rxDropped_reg;
endmodule

// file: verilog/rfs_host.sv
// Host end: Wishbone command registers driving single accesses on the register port.
`timescale 1ns/1ps
`include "rfs_map.svh"
module rfs_host (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic [31:0]      wbDatR,
  output logic             wbAck,
  // Register port
  rfs_link_if.host         link
);
  import rfs_pkg::*;

  rfs_host_state_type state_reg;
  rfs_addr_type       addr_reg;
  rfs_word_type       wrData_reg;
  rfs_word_type       rdData_reg;
  logic               write_reg;
  logic               wbAck_reg;
  logic [31:0]        wbDatR_reg;
  logic               wbReq;
  logic               start;

  assign wbReq = wbCyc && wbStb && !wbAck_reg;
  assign start = wbReq && wbWe && (wbAdr == `RFS_WB_CMD) && wbSel[0] && (state_reg == HIdle);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wbAck_reg <= 1'b0;
    end else begin
      wbAck_reg <= wbReq;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrData_reg <= 16'h0000;
    end else if (wbReq && wbWe && wbAdr == `RFS_WB_WDATA) begin
      if (wbSel[0]) begin
        wrData_reg[7:0] <= wbDatW[7:0];
      end
      if (wbSel[1]) begin
        wrData_reg[15:8] <= wbDatW[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wbDatR_reg <= 32'h00000000;
    end else if (wbReq && !wbWe) begin
      case (wbAdr)
        `RFS_WB_CMD:   wbDatR_reg <= {23'h000000, write_reg, addr_reg};
        `RFS_WB_WDATA: wbDatR_reg <= {16'h0000, wrData_reg};
        `RFS_WB_RDATA: wbDatR_reg <= {15'h0000, state_reg == HReq, rdData_reg};
        default:       wbDatR_reg <= 32'h00000000;
      endcase
    end
  end

  // A command written while an access is in flight is ignored; software polls the busy bit.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg  <= HIdle;
      addr_reg   <= 8'h00;
      write_reg  <= 1'b0;
      rdData_reg <= 16'h0000;
    end else begin
      case (state_reg)
        HIdle: begin
          if (start) begin
            addr_reg  <= wbDatW[7:0];
            write_reg <= wbDatW[`RFS_WB_B_WRITE];
            state_reg <= HReq;
          end
        end
        HReq: begin
          if (link.regAck) begin
            if (!write_reg) begin
              rdData_reg <= link.regRdData;
            end
            state_reg <= HIdle;
          end
        end
        default: state_reg <= HIdle;
      endcase
    end
  end

  // Auto enqueue forces the manual bit low in the same write.
  always_comb begin
    link.regWrData = wrData_reg;
    if (addr_reg == `RFS_OFF_TXCMD && wrData_reg[`RFS_B_AUTO]) begin
      link.regWrData[`RFS_B_SINGLE] = 1'b0;
    end
  end

  assign link.regAddr = addr_reg;
  assign link.regWr   = (state_reg == HReq) && write_reg;
  assign link.regRd   = (state_reg == HReq) && !write_reg;
  assign wbAck        = wbAck_reg;
  assign wbDatR       = wbDatR_reg;
endmodule

// file: dv/rfs_link_props.sv
// Concurrent checks on the register port between the host end and the device end.
`timescale 1ns/1ps
`include "rfs_map.svh"
module rfs_link_props (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  // Register port
  input wire rfs_pkg::rfs_addr_type regAddr,
  input wire rfs_pkg::rfs_word_type regWrData,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire rfs_pkg::rfs_word_type regRdData,
  input wire logic                 regAck
);
  import rfs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Handshake
  // ****************************************
  sequence s_req;
    (regWr || regRd) && !regAck;
  endsequence
  sequence s_read(a);
    regRd && !regAck && regAddr == a ##1 regAck;
  endsequence

  a_ack_next: assert property (s_req |=> regAck)
    else $error("register access not answered in the next cycle");
  a_ack_pulse: assert property (regAck |=> !regAck)
    else $error("register answer longer than one cycle");
  a_ack_cause: assert property ($rose(regAck) |-> $past(regWr || regRd))
    else $error("register answer without a request");
  a_req_hold: assert property (s_req |=> $stable(regAddr) && $stable(regWrData) && $stable(regWr) && $stable(regRd))
    else $error("register request changed before its answer");
  a_req_drop: assert property (regAck |=> !regWr && !regRd)
    else $error("register request not released after its answer");
  a_one_kind: assert property (!(regWr && regRd))
    else $error("read and write requested together");

  // ****************************************
  // Status word and byte count contents
  // ****************************************
  a_empty_zero: assert property (s_read(`RFS_OFF_STATUS) |-> regRdData[15] || regRdData == 16'h0000)
    else $error("status word not clear while no frame is pending");
  a_bcast_group: assert property (s_read(`RFS_OFF_STATUS) |-> !regRdData[7] || regRdData[6])
    else $error("broadcast frame without the group flag");
  a_addr_class: assert property (s_read(`RFS_OFF_STATUS) |-> !regRdData[15] || (regRdData[6] ^ regRdData[5]))
    else $error("frame not exactly one of unicast and group");
  a_runt_type: assert property (s_read(`RFS_OFF_STATUS) |-> !(regRdData[1] && regRdData[3]))
    else $error("type flag set on a runt frame");
  a_status_rsvd: assert property (s_read(`RFS_OFF_STATUS) |-> regRdData[9:8] == 2'h0)
    else $error("reserved status bits set");
  a_count_width: assert property (s_read(`RFS_OFF_BYTES) |-> regRdData[15:12] == 4'h0)
    else $error("byte count wider than twelve bits");
endmodule

// file: dv/tb_top.sv
// Self-checking bench joining the host end and the device end over the register port.
`timescale 1ns/1ps
`include "rfs_map.svh"
module tb_top;
  import rfs_pkg::*;
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [3:0]   wbAdr = 4'h0, wbSel = 4'hf;
  logic [31:0]  wbDatW = 32'h0, wbDatR;
  logic         rxFrameDone = 1'b0, rxTcpBad = 1'b0, rxUdpBad = 1'b0, rxSymbolErr = 1'b0;
  logic         rxRunt = 1'b0, rxCrcBad = 1'b0, passBadFrame = 1'b0;
  logic         txFramePrepared = 1'b0, txFrameSent = 1'b0, txEnqueue, rxDropped;
  logic [47:0]  rxDestAddr = 48'h0;
  rfs_word_type rxLenType = 16'h0;
  logic [11:0]  rxByteCount = 12'h0;
  logic [12:0]  txFreeBytes = 13'h0;
  int           fail_count = 0, n_tests = 0, enqCount = 0;
  rfs_word_type expStat[$], expBytes[$];

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (txEnqueue === 1'b1) enqCount++;

  rfs_link_if rfs_link_if_inst ();
  rfs_host rfs_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .link(rfs_link_if_inst));
  rfs_device rfs_device_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(rfs_link_if_inst),
    .rxFrameDone(rxFrameDone), .rxDestAddr(rxDestAddr), .rxLenType(rxLenType), .rxByteCount(rxByteCount),
    .rxTcpBad(rxTcpBad), .rxUdpBad(rxUdpBad), .rxSymbolErr(rxSymbolErr), .rxRunt(rxRunt),
    .rxCrcBad(rxCrcBad), .passBadFrame(passBadFrame), .txFramePrepared(txFramePrepared),
    .txFrameSent(txFrameSent), .txFreeBytes(txFreeBytes), .txEnqueue(txEnqueue), .rxDropped(rxDropped));
  rfs_link_props rfs_link_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(rfs_link_if_inst.regAddr), .regWrData(rfs_link_if_inst.regWrData), .regWr(rfs_link_if_inst.regWr),
    .regRd(rfs_link_if_inst.regRd), .regRdData(rfs_link_if_inst.regRdData), .regAck(rfs_link_if_inst.regAck));

  // ****************************************
  // Reporting
  // ****************************************
  task end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // ****************************************
  // Bus access
  // ****************************************
  // Hangs end the run at once, since later checks would only repeat the failure.
  task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int k;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      end_of_test();
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task dev(input logic we, input rfs_addr_type a, input rfs_word_type d, output rfs_word_type r);
    logic [31:0] t;
    int k;
    if (we) wb(1'b1, `RFS_WB_WDATA, {16'h0, d}, t);
    wb(1'b1, `RFS_WB_CMD, {23'h0, we, a}, t);
    k = 0;
    do begin
      wb(1'b0, `RFS_WB_RDATA, 32'h0, t);
      k++;
    end while (t[16] !== 1'b0 && k < 20);
    if (k >= 20) begin
      fail_count++;
      end_of_test();
    end
    r = t[15:0];
  endtask
  task rd_chk(input rfs_addr_type a, input rfs_word_type e);
    rfs_word_type r;
    dev(1'b0, a, 16'h0, r);
    cmp_word({16'h0, r}, {16'h0, e});
  endtask

  // ****************************************
  // Receive frames
  // ****************************************
  function automatic rfs_word_type exp_status(input logic [47:0] da, input rfs_word_type lt,
                                              input logic [11:0] bc, input logic [4:0] fl);
    rfs_word_type s;
    s = 16'h8000;
    s[11] = fl[4];
    s[10] = fl[3];
    s[7] = &da;
    s[6] = da[40];
    s[5] = !da[40];
    s[4] = fl[2];
    s[3] = !fl[1] && lt > 16'h05dc;
    s[2] = bc > 12'h7d0;
    s[1] = fl[1];
    s[0] = fl[0];
    return s;
  endfunction
  task push_frame(input logic [47:0] da, input rfs_word_type lt, input logic [11:0] bc, input logic [4:0] fl);
    logic bad;
    bad = bc > 12'h7d0 || fl[1] || fl[0];
    @(posedge sys_clk);
    rxFrameDone <= 1'b1;
    rxDestAddr <= da;
    rxLenType <= lt;
    rxByteCount <= bc;
    {rxTcpBad, rxUdpBad, rxSymbolErr, rxRunt, rxCrcBad} <= fl;
    @(posedge sys_clk);
    rxFrameDone <= 1'b0;
    #1;
    if ((bad && !passBadFrame) || expStat.size() == 8) cmp_flag(rxDropped, 1'b1);
    else begin
      cmp_flag(rxDropped, 1'b0);
      expStat.push_back(exp_status(da, lt, bc, fl));
      expBytes.push_back({4'h0, bc});
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [47:0] da;
    rfs_word_type lt, r;
    logic [11:0] bc;
    logic [31:0] t;
    int n;
    void'($urandom(70781));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(`RFS_OFF_TXCMD, 16'h0000);
    rd_chk(`RFS_OFF_STATUS, 16'h0000);
    rd_chk(8'h10, 16'h0000);
    wb(1'b0, 4'hc, 32'h0, t);
    cmp_word(t, 32'h0);
    // The first round passes every frame and overfills the queue by one.
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      passBadFrame <= !i[0];
      n = (i == 0) ? 9 : $urandom_range(1, 9);
      repeat (n) begin
        da = ($urandom_range(0, 3) == 0) ? 48'hffffffffffff : 48'({$urandom(), $urandom()});
        lt = ($urandom_range(0, 2) == 0) ? 16'h05dc + 16'($urandom_range(0, 1)) : 16'($urandom());
        bc = ($urandom_range(0, 2) == 0) ? 12'h7d0 + 12'($urandom_range(0, 1)) : 12'($urandom());
        push_frame(da, lt, bc, 5'($urandom()));
      end
      rd_chk(`RFS_OFF_FCOUNT, 16'(expStat.size()));
      while (expStat.size() > 0) begin
        rd_chk(`RFS_OFF_STATUS, expStat[0]);
        rd_chk(`RFS_OFF_STATUS, expStat.pop_front());
        rd_chk(`RFS_OFF_BYTES, expBytes.pop_front());
        dev(1'b1, `RFS_OFF_RXCMD, 16'h0001, r);
      end
      rd_chk(`RFS_OFF_STATUS, 16'h0000);
    end
    n = enqCount;
    dev(1'b1, `RFS_OFF_TXCMD, 16'h0001, r);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_word(32'(enqCount - n), 32'h1);
    rd_chk(`RFS_OFF_TXCMD, 16'h0001);
    @(posedge sys_clk);
    txFrameSent <= 1'b1;
    @(posedge sys_clk);
    txFrameSent <= 1'b0;
    rd_chk(`RFS_OFF_TXCMD, 16'h0000);
    n = enqCount;
    dev(1'b1, `RFS_OFF_TXCMD, 16'h0005, r);
    repeat (3) begin
      @(posedge sys_clk);
      txFramePrepared <= 1'b1;
      @(posedge sys_clk);
      txFramePrepared <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_word(32'(enqCount - n), 32'h3);
    rd_chk(`RFS_OFF_TXCMD, 16'h0004);
    dev(1'b1, `RFS_OFF_TXCMD, 16'h0000, r);
    @(posedge sys_clk);
    txFreeBytes <= 13'h0032;
    dev(1'b1, `RFS_OFF_TXREQ, 16'h0064, r);
    dev(1'b1, `RFS_OFF_TXCMD, 16'h0002, r);
    rd_chk(`RFS_OFF_TXCMD, 16'h0002);
    rd_chk(`RFS_OFF_IRQ, 16'h0000);
    @(posedge sys_clk);
    txFreeBytes <= 13'h0064;
    rd_chk(`RFS_OFF_IRQ, 16'h0040);
    rd_chk(`RFS_OFF_TXCMD, 16'h0000);
    dev(1'b1, `RFS_OFF_IRQ, 16'h0040, r);
    wb(1'b0, `RFS_WB_CMD, 32'h0, t);
    cmp_word(t, 32'h00000192);
    wb(1'b0, `RFS_WB_WDATA, 32'h0, t);
    cmp_word(t, 32'h00000040);
    rd_chk(`RFS_OFF_IRQ, 16'h0000);
    end_of_test();
  end
endmodule
